// File: hdl/smed_detector.sv
/*
  Receive-side message end detector with an Avalon-MM register slave.
  Assumes characters come from a receiver on the same clock, one pulse each,
  and that start and transmit-end pulses come from neighbouring logic.
*/
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
// Notes on behaviour
// - With the gap condition on, the message ends once idle time after a character exceeds the gap limit.
// - The gap limit is in bit times, defaults to 12, reaches 65535, and never exceeds eight seconds.
// - Every received character restarts the gap timer from zero.
// - With max length on, the message ends when the set count, 1 to 1023, has arrived.
// - A timeout ending a message early still delivers every character received.
// - In length-field mode the length is read from the message and the end follows that many characters.
// - In end-character mode a character equal to the terminator ends the message.
// - The end sequence has up to five positions, each an exact byte or a don't-care.
// - Leading don't-care positions are not part of the match.
// - Trailing don't-care positions are part of the match and must be received.
// - Pattern ignore, 7A, 7A, ignore, ignore ends two characters after two 7A bytes.
// - With the response timeout on, the first reply character must come before the wait limit.
// - Several end conditions may be on; the first one met ends the message.
// - The message timeout starts with the start condition, ends the message on expiry, default 200 ms.
// - The response timer starts when a transmission ends and flags an error if no character comes.
// - Length field uses a 1-based position, a size of one, two or four bytes and m uncounted trailers.
`timescale 1ns/10ps
`default_nettype none
`include "smed_consts.svh"

module smed_detector
  import smed_pkg::*;
#(
  parameter int MS_CYCLES = `SMED_MS_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic start_in,
  input wire logic tx_done_in,
  output logic msg_end_out,
  output logic [10:0] msg_len_out,
  output logic [5:0] end_cause_out,
  output logic resp_err_out,
  output logic active_out
);

  typedef struct packed {
    smed_state_type state;
    logic wait_req;
    logic [31:0] rdata;
    logic [6:0] ctrl;
    logic [15:0] baud;
    logic [15:0] gap_lim;
    logic [9:0] max_len;
    logic [9:0] len_n;
    logic [1:0] len_sz;
    logic [7:0] len_m;
    logic [7:0] end_ch;
    logic [39:0] seq;
    logic [4:0] care;
    logic [15:0] msg_to;
    logic [15:0] resp_to;
    logic [10:0] cnt;
    logic [39:0] hist;
    logic [31:0] len_val;
    logic len_ok;
    logic [15:0] baud_cnt;
    logic [16:0] gap_cnt;
    logic [16:0] gap_ms;
    logic [15:0] ms_cnt;
    logic [16:0] msg_ms;
    logic resp_act;
    logic [16:0] resp_ms;
    smed_end_type ev;
    logic resp_err;
    logic err_sticky;
  } smed_regs_type;

  smed_regs_type q_r;
  smed_regs_type q_nxt;
  smed_bus_req_type req;
  smed_char_type chr;

  assign req = '{read: avs_read_in, write: avs_write_in,
                 address: avs_address_in, writedata: avs_writedata_in};
  assign chr = '{valid: rx_valid_in, data: rx_data_in};

  // Number of bytes in the length field for a size code.
  function automatic logic [2:0] len_bytes(input logic [1:0] sz);
    case (sz)
      2'h0: len_bytes = 3'h1;
      2'h1: len_bytes = 3'h2;
      default: len_bytes = 3'h4;
    endcase
  endfunction

  // Checks the newest five characters against the end sequence.
  function automatic logic seq_hit(input logic [39:0] hist, input logic [39:0] seq,
                                   input logic [4:0] care, input logic [10:0] cnt);
    logic hit;
    logic seen;
    logic [10:0] need;
    hit = |care;
    seen = 1'b0;
    need = 11'h000;
    for (int i = 0; i < 5; i++) begin
      seen = seen | care[i];
      if (seen) begin
        need = need + 11'h001;
      end
      if (care[i] && (hist[8*(4-i) +: 8] != seq[8*i +: 8])) begin
        hit = 1'b0;
      end
    end
    seq_hit = hit && (cnt >= need);
  endfunction

  always_comb begin
    logic ms_tick;
    logic bit_tick;
    logic [10:0] pos;
    logic [39:0] nh;
    logic [31:0] nlen;
    logic nok;
    logic [34:0] total;
    logic [5:0] cause;
    ms_tick = 1'b0;
    bit_tick = 1'b0;
    pos = 11'h000;
    nh = 40'h00_0000_0000;
    nlen = 32'h0000_0000;
    nok = 1'b0;
    total = 35'h0;
    cause = 6'h00;
    q_nxt = q_r;
    q_nxt.ev.done = 1'b0;
    q_nxt.resp_err = 1'b0;

    // A request is answered one cycle after it is seen.
    q_nxt.wait_req = !((req.read || req.write) && q_r.wait_req);
    if (req.read && q_r.wait_req) begin
      case (req.address)
        `SMED_OFS_CTRL: q_nxt.rdata = 32'(q_r.ctrl);
        `SMED_OFS_BAUD: q_nxt.rdata = 32'(q_r.baud);
        `SMED_OFS_GAP: q_nxt.rdata = 32'(q_r.gap_lim);
        `SMED_OFS_MAXLEN: q_nxt.rdata = 32'(q_r.max_len);
        `SMED_OFS_LENCFG: q_nxt.rdata = {8'h00, q_r.len_m, 2'h0, q_r.len_sz, 2'h0, q_r.len_n};
        `SMED_OFS_ENDCH: q_nxt.rdata = 32'(q_r.end_ch);
        `SMED_OFS_SEQLO: q_nxt.rdata = q_r.seq[31:0];
        `SMED_OFS_SEQHI: q_nxt.rdata = {19'h00000, q_r.care, q_r.seq[39:32]};
        `SMED_OFS_MSGTO: q_nxt.rdata = 32'(q_r.msg_to);
        `SMED_OFS_RESPTO: q_nxt.rdata = 32'(q_r.resp_to);
        `SMED_OFS_STATUS: q_nxt.rdata = {7'h00, q_r.err_sticky, 1'b0, q_r.ev.cause,
                                          q_r.state == SMED_RECV, 5'h00, q_r.cnt};
        default: q_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (req.write && !q_r.wait_req) begin
      case (req.address)
        `SMED_OFS_CTRL: q_nxt.ctrl = req.writedata[6:0];
        `SMED_OFS_BAUD: q_nxt.baud = req.writedata[15:0];
        `SMED_OFS_GAP: q_nxt.gap_lim = req.writedata[15:0];
        `SMED_OFS_MAXLEN: begin
          if (req.writedata[9:0] != 10'h000) begin
            q_nxt.max_len = req.writedata[9:0];
          end
        end
        `SMED_OFS_LENCFG: begin
          q_nxt.len_n = req.writedata[9:0];
          q_nxt.len_sz = req.writedata[13:12];
          q_nxt.len_m = req.writedata[23:16];
        end
        `SMED_OFS_ENDCH: q_nxt.end_ch = req.writedata[7:0];
        `SMED_OFS_SEQLO: q_nxt.seq[31:0] = req.writedata;
        `SMED_OFS_SEQHI: begin
          q_nxt.seq[39:32] = req.writedata[7:0];
          q_nxt.care = req.writedata[12:8];
        end
        `SMED_OFS_MSGTO: q_nxt.msg_to = req.writedata[15:0];
        `SMED_OFS_RESPTO: q_nxt.resp_to = req.writedata[15:0];
        `SMED_OFS_STATUS: begin
          if (req.writedata[`SMED_BIT_ERR]) begin
            q_nxt.err_sticky = 1'b0;
          end
        end
        default: q_nxt.rdata = q_r.rdata;
      endcase
    end

    // Shared prescalers: one millisecond and one serial bit period.
    ms_tick = (q_r.ms_cnt >= 16'(MS_CYCLES - 1));
    q_nxt.ms_cnt = ms_tick ? 16'h0000 : q_r.ms_cnt + 16'h0001;
    bit_tick = (q_r.baud_cnt + 16'h0001 >= q_r.baud);
    q_nxt.baud_cnt = bit_tick ? 16'h0000 : q_r.baud_cnt + 16'h0001;

    // Response wait: armed at transmit end, disarmed by any character.
    if (tx_done_in && q_r.ctrl[`SMED_BIT_RSP_EN]) begin
      q_nxt.resp_act = 1'b1;
      q_nxt.resp_ms = 17'h00000;
    end else if (chr.valid) begin
      q_nxt.resp_act = 1'b0;
    end else if (q_r.resp_act) begin
      if (q_r.resp_ms >= 17'(q_r.resp_to)) begin
        q_nxt.resp_act = 1'b0;
        q_nxt.resp_err = 1'b1;
      end else if (ms_tick) begin
        q_nxt.resp_ms = q_r.resp_ms + 17'h00001;
      end
    end
    if (q_nxt.resp_err) begin
      q_nxt.err_sticky = 1'b1;
    end

    case (q_r.state)
      SMED_IDLE: begin
        if (start_in) begin
          q_nxt.state = SMED_RECV;
          q_nxt.cnt = 11'h000;
          q_nxt.hist = 40'h00_0000_0000;
          q_nxt.len_val = 32'h0000_0000;
          q_nxt.len_ok = 1'b0;
          q_nxt.gap_cnt = 17'h00000;
          q_nxt.gap_ms = 17'h00000;
          q_nxt.msg_ms = 17'h00000;
        end
      end
      SMED_RECV: begin
        if (chr.valid) begin
          pos = q_r.cnt + 11'h001;
          nh = {q_r.hist[31:0], chr.data};
          nlen = q_r.len_val;
          nok = q_r.len_ok;
          if (!q_r.len_ok && 11'(q_r.len_n) <= pos) begin
            nlen = {q_r.len_val[23:0], chr.data};
            nok = (pos == 11'(q_r.len_n) + 11'(len_bytes(q_r.len_sz)) - 11'h001);
          end
          q_nxt.cnt = pos;
          q_nxt.hist = nh;
          q_nxt.len_val = nlen;
          q_nxt.len_ok = nok;
          q_nxt.gap_cnt = 17'h00000;
          q_nxt.gap_ms = 17'h00000;
          // The freshly shifted length is used, so a field that this character completes counts at once.
          total = 35'(q_r.len_n) + 35'(len_bytes(q_r.len_sz)) - 35'h1 + 35'(nlen) + 35'(q_r.len_m);
          cause[1] = q_r.ctrl[`SMED_BIT_MAX_EN] && (pos >= 11'(q_r.max_len));
          cause[2] = q_r.ctrl[`SMED_BIT_LEN_EN] && nok && (35'(pos) >= total);
          cause[3] = q_r.ctrl[`SMED_BIT_CHR_EN] && (chr.data == q_r.end_ch);
          cause[4] = q_r.ctrl[`SMED_BIT_SEQ_EN] && seq_hit(nh, q_r.seq, q_r.care, pos);
        end else begin
          if (bit_tick && q_r.cnt != 11'h000 && q_r.gap_cnt[16] == 1'b0) begin
            q_nxt.gap_cnt = q_r.gap_cnt + 17'h00001;
          end
          if (ms_tick && q_r.cnt != 11'h000 && q_r.gap_ms < `SMED_GAP_CAP_MS) begin
            q_nxt.gap_ms = q_r.gap_ms + 17'h00001;
          end
          cause[0] = q_r.ctrl[`SMED_BIT_GAP_EN] && q_r.cnt != 11'h000 &&
                     (q_r.gap_cnt > 17'(q_r.gap_lim) || q_r.gap_ms >= `SMED_GAP_CAP_MS);
        end
        if (ms_tick) begin
          q_nxt.msg_ms = q_r.msg_ms + 17'h00001;
        end
        cause[5] = q_r.ctrl[`SMED_BIT_MTO_EN] && (q_r.msg_ms >= 17'(q_r.msg_to));
        if (cause != 6'h00) begin
          q_nxt.state = SMED_IDLE;
          q_nxt.ev.done = 1'b1;
          q_nxt.ev.length = q_nxt.cnt;
          q_nxt.ev.cause = cause;
        end
      end
      default: q_nxt.state = SMED_IDLE;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      q_r <= '0;
      q_r.state <= SMED_IDLE;
      q_r.ctrl <= `SMED_RST_CTRL;
      q_r.baud <= `SMED_RST_BAUD;
      q_r.gap_lim <= `SMED_RST_GAP;
      q_r.max_len <= `SMED_RST_MAXLEN;
      q_r.len_n <= `SMED_RST_LEN_N;
      q_r.wait_req <= 1'b1;
      q_r.msg_to <= `SMED_RST_MSGTO;
      q_r.resp_to <= `SMED_RST_RESPTO;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avs_readdata_out = q_r.rdata;
  assign avs_waitrequest_out = q_r.wait_req;
  assign msg_end_out = q_r.ev.done;
  assign msg_len_out = q_r.ev.length;
  assign end_cause_out = q_r.ev.cause;
  assign resp_err_out = q_r.resp_err;
  // The one-hot receive bit is the open-message flag itself, so no decode sits behind the pin.
  assign active_out = q_r.state[1];

endmodule

`default_nettype wire

// File: hdl/smed_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the
  serial receive message end detector. Assumes a 50 MHz module clock.
*/
`ifndef SMED_CONSTS_SVH
`define SMED_CONSTS_SVH

`define SMED_CLK_PERIOD_NS 20
`define SMED_MS_NS 1000000
`define SMED_MS_CYCLES (`SMED_MS_NS / `SMED_CLK_PERIOD_NS)
`define SMED_GAP_CAP_MS 17'h01F40

`define SMED_OFS_CTRL 6'h00
`define SMED_OFS_BAUD 6'h04
`define SMED_OFS_GAP 6'h08
`define SMED_OFS_MAXLEN 6'h0C
`define SMED_OFS_LENCFG 6'h10
`define SMED_OFS_ENDCH 6'h14
`define SMED_OFS_SEQLO 6'h18
`define SMED_OFS_SEQHI 6'h1C
`define SMED_OFS_MSGTO 6'h20
`define SMED_OFS_RESPTO 6'h24
`define SMED_OFS_STATUS 6'h28

`define SMED_BIT_GAP_EN 0
`define SMED_BIT_MAX_EN 1
`define SMED_BIT_LEN_EN 2
`define SMED_BIT_CHR_EN 3
`define SMED_BIT_SEQ_EN 4
`define SMED_BIT_MTO_EN 5
`define SMED_BIT_RSP_EN 6
`define SMED_BIT_ERR 24

`define SMED_RST_CTRL 7'h00
`define SMED_RST_BAUD 16'h01B2
`define SMED_RST_GAP 16'h000C
`define SMED_RST_MAXLEN 10'h3FF
`define SMED_RST_LEN_N 10'h001
`define SMED_RST_MSGTO 16'h00C8
`define SMED_RST_RESPTO 16'h00C8

`endif

// File: hdl/smed_pkg.sv
/*
  Types of the serial receive message end detector.
  Assumes smed_consts.svh for all numeric values.
*/
package smed_pkg;

  typedef enum logic [1:0] {
    SMED_IDLE = 2'b01,
    SMED_RECV = 2'b10
  } smed_state_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } smed_bus_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } smed_char_type;

  typedef struct packed {
    logic done;
    logic [10:0] length;
    logic [5:0] cause;
  } smed_end_type;

endpackage

// File: testbench/smed_chk.sv
/*
  Port checker of the serial receive message end detector.
  Assumes it is bound to every instance of smed_detector.
*/
`timescale 1ns/10ps
`default_nettype none
module smed_chk (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic rx_valid_in,
  input wire logic start_in,
  input wire logic tx_done_in,
  input wire logic msg_end_out,
  input wire logic [10:0] msg_len_out,
  input wire logic [5:0] end_cause_out,
  input wire logic resp_err_out,
  input wire logic active_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [10:0] cnt_r;
  logic armed_r;
  logic [1:0] grace_r;
  // The grace window keeps two cycles of armed_r history; a reply on the very tick that expired disarms the wait first, so no error pulse trails it.
  always_ff @(posedge clock_in) begin
    if (rst_in || (start_in && !active_out)) begin
      cnt_r <= 11'h000;
    end else if (rx_valid_in && active_out) begin
      cnt_r <= cnt_r + 11'h001;
    end
    armed_r <= !rst_in && (tx_done_in || (armed_r && !rx_valid_in));
    grace_r <= {grace_r[0], armed_r};
  end
  wait_ans_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus request not answered in one cycle");
  wait_rel_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  end_pulse_a: assert property (msg_end_out |=> !msg_end_out)
    else $error("message end pulse longer than one cycle");
  end_close_a: assert property (msg_end_out |-> !active_out && end_cause_out != 6'h00)
    else $error("message ended without cause or still open");
  start_open_a: assert property (start_in && !active_out |=> active_out)
    else $error("start did not open a message");
  len_match_a: assert property (msg_end_out |-> msg_len_out == cnt_r)
    else $error("ended length differs from characters taken");
  end_hold_a: assert property (!msg_end_out && !$past(rst_in) |-> $stable(msg_len_out) && $stable(end_cause_out))
    else $error("length or cause changed without an end");
  resp_pulse_a: assert property (resp_err_out |=> !resp_err_out)
    else $error("response error pulse longer than one cycle");
  resp_arm_a: assert property (resp_err_out |-> armed_r || grace_r != 2'b00)
    else $error("response error without a pending wait");
endmodule
bind smed_detector smed_chk chk (.clock_in(clock_in), .rst_in(rst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out), .rx_valid_in(rx_valid_in),
  .start_in(start_in), .tx_done_in(tx_done_in), .msg_end_out(msg_end_out), .msg_len_out(msg_len_out),
  .end_cause_out(end_cause_out), .resp_err_out(resp_err_out), .active_out(active_out));
`default_nettype wire

// File: testbench/smed_peer.sv
/*
  Model of the serial device on the far side, one pulse per character.
  Assumes send is called right after a rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module smed_peer (
  input wire logic clock_in,
  output logic rx_valid_out,
  output logic [7:0] rx_data_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'hA5;
  end
  // Between characters the data lines carry the inverse of the last one, so a stale capture cannot pass.
  task automatic send(input logic [7:0] b, input int idle);
    @(posedge clock_in);
    rx_valid_out <= 1'b1;
    rx_data_out <= b;
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b;
    repeat (idle) @(posedge clock_in);
  endtask
endmodule
`default_nettype wire

// File: testbench/serial_rx_message_end_detector_bench.sv
/*
  Self-checking bench of the message end detector.
  Assumes the peer model supplies the characters.
*/
`timescale 1ns/10ps
`default_nettype none
`include "smed_consts.svh"
module serial_rx_message_end_detector_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h00000000;
  logic start = 1'b0;
  logic txd = 1'b0;
  logic [31:0] rdata;
  logic wreq;
  logic rx_v;
  logic [7:0] rx_d;
  logic m_end;
  logic [10:0] m_len;
  logic [5:0] m_cause;
  logic r_err;
  logic act;
  logic [31:0] q;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  smed_peer peer (.clock_in(clk), .rx_valid_out(rx_v), .rx_data_out(rx_d));
  // A millisecond is cut to 50 clocks so the timeouts finish in a few hundred cycles.
  smed_detector #(.MS_CYCLES(50)) dut (.clock_in(clk), .rst_in(rst), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .rx_valid_in(rx_v), .rx_data_in(rx_d), .start_in(start), .tx_done_in(txd), .msg_end_out(m_end),
    .msg_len_out(m_len), .end_cause_out(m_cause), .resp_err_out(r_err), .active_out(act));
  task automatic complete_run;
    $display("n_tests=%0d n_fail=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check(q, e);
  endtask
  task automatic send_msg(input logic [47:0] s, input int n);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    check(32'(act), 32'h00000001);
    for (int i = 0; i < n; i++) begin
      peer.send(s[8*(n-1-i) +: 8], (i == n - 1) ? 0 : 3);
    end
  endtask
  task automatic wait_end(input logic [10:0] len, input logic [5:0] cause);
    int n;
    n = 0;
    while (m_end !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check(32'(m_end), 32'h00000001);
    check(32'(m_len), 32'(len));
    check(32'(m_cause), 32'(cause));
    check(32'(act), 32'h00000000);
    @(posedge clk);
  endtask
  task automatic watch_err(input logic reply, input logic [31:0] e);
    logic s;
    s = 1'b0;
    txd <= 1'b1;
    @(posedge clk);
    txd <= 1'b0;
    if (reply) begin
      peer.send(8'h5A, 0);
    end
    repeat (150) begin
      @(posedge clk);
      s = s | (r_err === 1'b1);
    end
    check(32'(s), e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(`SMED_OFS_GAP, 32'h0000000C);
    rd_chk(`SMED_OFS_MAXLEN, 32'h000003FF);
    rd_chk(`SMED_OFS_MSGTO, 32'h000000C8);
    rd_chk(`SMED_OFS_RESPTO, 32'h000000C8);
    rd_chk(6'h3C, 32'h00000000);
    bus(1'b1, `SMED_OFS_BAUD, 32'h00000004);
    bus(1'b1, `SMED_OFS_ENDCH, 32'h0000000D);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000008);
    send_msg(48'h410D, 2);
    wait_end(11'h002, 6'h08);
    bus(1'b1, `SMED_OFS_MAXLEN, 32'h00000003);
    bus(1'b1, `SMED_OFS_MAXLEN, 32'h00000000);
    rd_chk(`SMED_OFS_MAXLEN, 32'h00000003);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000002);
    send_msg(48'h010203, 3);
    wait_end(11'h003, 6'h02);
    bus(1'b1, `SMED_OFS_GAP, 32'h00000002);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000001);
    send_msg(48'h102030405060, 6);
    wait_end(11'h006, 6'h01);
    bus(1'b1, `SMED_OFS_LENCFG, 32'h00011001);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000004);
    send_msg(48'h0002556677, 5);
    wait_end(11'h005, 6'h04);
    bus(1'b1, `SMED_OFS_SEQLO, 32'h007A7A00);
    bus(1'b1, `SMED_OFS_SEQHI, 32'h00000600);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000010);
    send_msg(48'h7A117A7A3344, 6);
    wait_end(11'h006, 6'h10);
    send_msg(48'h7A7A3344, 4);
    wait_end(11'h004, 6'h10);
    bus(1'b1, `SMED_OFS_MAXLEN, 32'h00000004);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000012);
    send_msg(48'h7A7A3344, 4);
    wait_end(11'h004, 6'h12);
    bus(1'b1, `SMED_OFS_MSGTO, 32'h00000002);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000022);
    send_msg(48'h0102, 2);
    wait_end(11'h002, 6'h20);
    bus(1'b1, `SMED_OFS_RESPTO, 32'h00000001);
    bus(1'b1, `SMED_OFS_CTRL, 32'h00000040);
    watch_err(1'b0, 32'h00000001);
    bus(1'b0, `SMED_OFS_STATUS, 32'h00000000);
    check(32'(q[24]), 32'h00000001);
    bus(1'b1, `SMED_OFS_STATUS, 32'h01000000);
    bus(1'b0, `SMED_OFS_STATUS, 32'h00000000);
    check(32'(q[24]), 32'h00000000);
    watch_err(1'b1, 32'h00000000);
    complete_run;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
endmodule
`default_nettype wire
